// ===== rtl/mbp_port.sv
// Contract
// R1: one 16-bit two-way bus carries address, command and data in phases.
// R2: phase one is captured on a rising bus clock edge.
// R3: phase two, low address plus command, is captured on rising ALE.
// R4: host samples the claim or request on ALE falling.
// R5: host strobes command in data phase and to acknowledge backoff.
// R6: drive select low while ALE high to claim; otherwise release.
// R7: with ALE low, drive select to ask backoff; host acks by command.
// R8: in stop-clock mode the select line may be pulled to wake clock.
// R9: ready output is a tristate cycle-extension request.
// R10: bit 0 is memory/io in phase one, write/read in phase two.
// R11: bit 1 is io/dma (0 for memory) then byte-high enable.
// R12: phase two bit 2 is the fast-timing bit.
// R13: bits marked unchanged are never relied upon by the decoder.
// R14: memory phase one: bits 15..2 are address 23..10, io/dma 0, mem 1.
// R15: memory phase two: address 9..0 high, control low; phase three data.
// R16: host drives high address first, then low address and raises ALE.
// R17: own cycle is claimed; fast bit 1 selects zero-wait timing.
// R18: host sees claim on bus clock rise and drops ALE there.
// R19: host drives write data or floats the bus for reads.
// R20: fast cycle has no wait unless ready pulled low after command.
// R21: fast cycle returns ready high on a falling bus clock edge.
// R22: host ends command on the edge it samples ready high.
// R23: fast bit 0 means standard timing; ready released at once.
// R24: io cycle is memory/io 0 with io/dma 1.
// R25: reset floats select and ready and idles the cycle tracker.
module mbp_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // multiplexed bus pins
  input  wire logic        bus_clock,
  input  wire logic        ale,
  input  wire logic        cmd_n,
  input  wire logic [15:0] mux_bus_in,
  output logic      [15:0] mux_bus_out,
  output logic             mux_bus_oe,
  output logic             select_backoff_n_out,
  output logic             select_backoff_n_oe,
  output logic             iochrdy_out,
  output logic             iochrdy_oe,
  // decode window for phase-one address bits 23..10
  input  wire logic [13:0] win_base,
  input  wire logic [13:0] win_mask,
  // backoff and clock wake requests
  input  wire logic        req_change,
  input  wire logic        stop_clock_mode,
  input  wire logic        wake_req,
  output logic             backoff_ack,
  // user side of a claimed cycle
  output logic             cyc_start,
  output logic [23:0]      cyc_addr,
  output logic             cyc_write,
  output logic             cyc_bhe_n,
  output logic             cyc_fast,
  input  wire logic        busy,
  input  wire logic [15:0] rd_data,
  output logic [15:0]      wr_data,
  output logic             wr_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and phase capture

  logic [mbp_pkg::SYNC_W-1:0] sync_q;
  logic [15:0]                bus_s;
  logic                       cmd_s;
  logic                       ale_s;
  logic                       bclk_s;
  mbp_pkg::mbp_state_t        st;
  mbp_phase_if                ph ();

  // every pin from the bus passes two flops; costs 2 clk of latency
  mbp_sync #(
    .W       (mbp_pkg::SYNC_W),
    .RST_VAL (mbp_pkg::SYNC_RST)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({bus_clock, ale, cmd_n, mux_bus_in}),
    .q       (sync_q)
  );

  assign bus_s  = sync_q[15:0];
  assign cmd_s  = sync_q[mbp_pkg::SYNC_CMD_BIT];
  assign ale_s  = sync_q[mbp_pkg::SYNC_ALE_BIT];
  assign bclk_s = sync_q[mbp_pkg::SYNC_BCK_BIT];

  // phase one moves between cycles, foreign ones too, so a skip never decodes stale address
  assign ph.p1_en = ((st == mbp_pkg::ST_IDLE) || (st == mbp_pkg::ST_SKIP)) && !ale_s; // R2 R16

  mbp_phase u_phase (
    .clk     (clk),
    .reset_n (reset_n),
    .bus_s   (bus_s),
    .bclk_s  (bclk_s),
    .ale_s   (ale_s),
    .cmd_s   (cmd_s),
    .ph      (ph)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of phase one

  logic        p1_mem;
  logic        p1_iod;
  logic [13:0] p1_ahi;
  logic        hit;

  assign p1_mem = ph.p1[mbp_pkg::P1_MIO_BIT]; // R10
  assign p1_iod = ph.p1[mbp_pkg::P1_IOD_BIT]; // R11
  assign p1_ahi = ph.p1[mbp_pkg::P1_AHI_LSB +: mbp_pkg::AHI_W]; // R14

  // memory cycles only; io/dma set with memory is malformed, io is not ours
  assign hit = p1_mem && !p1_iod && (((p1_ahi ^ win_base) & win_mask) == 14'h0000); // R11 R14 R24

  ////////////////////////////////////////////////////////////////////////////
  // cycle tracker

  // foreign cycles park in skip so their command strobe is not taken as an ack
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= mbp_pkg::ST_IDLE; // R25
    end else begin
      case (st)
        mbp_pkg::ST_IDLE: begin
          if (ph.ale_rise) begin
            st <= hit ? mbp_pkg::ST_CLAIM : mbp_pkg::ST_SKIP; // R17
          end
        end
        mbp_pkg::ST_CLAIM: begin
          if (!ale_s) begin
            st <= mbp_pkg::ST_DATA; // R18
          end
        end
        mbp_pkg::ST_DATA: begin
          if (ph.cmd_fall) begin
            st <= mbp_pkg::ST_CMD; // R5
          end
        end
        mbp_pkg::ST_CMD: begin
          if (ph.cmd_rise) begin
            st <= mbp_pkg::ST_IDLE; // R22
          end
        end
        mbp_pkg::ST_SKIP: begin
          if (ph.cmd_rise) begin
            st <= mbp_pkg::ST_IDLE;
          end else if (ph.ale_rise) begin
            st <= hit ? mbp_pkg::ST_CLAIM : mbp_pkg::ST_SKIP;
          end
        end
        default: begin
          st <= mbp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched cycle description for the user side

  logic claim_done;
  assign claim_done = (st == mbp_pkg::ST_CLAIM) && !ale_s;

  // phase two bits 5..3 are never looked at
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_addr  <= mbp_pkg::ADDR_RST;
      cyc_write <= 1'b0;
      cyc_bhe_n <= 1'b1;
      cyc_fast  <= 1'b0;
      cyc_start <= 1'b0;
    end else begin
      cyc_start <= claim_done;
      if (claim_done) begin
        cyc_addr  <= {p1_ahi, ph.p2[mbp_pkg::P2_ALO_LSB +: mbp_pkg::ALO_W]}; // R15 R13
        cyc_write <= ph.p2[mbp_pkg::P2_WR_BIT]; // R10
        cyc_bhe_n <= ph.p2[mbp_pkg::P2_BHE_BIT]; // R11
        cyc_fast  <= ph.p2[mbp_pkg::P2_FAST_BIT]; // R12 R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data phase on the multiplexed bus

  logic next_bus_oe;
  assign next_bus_oe = !cyc_write &&
                       (((st == mbp_pkg::ST_DATA) && ph.cmd_fall) ||
                        ((st == mbp_pkg::ST_CMD) && !ph.cmd_rise)); // R19 R1

  // read data follows rd_data while driven; write data tracks the bus
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_bus_out <= mbp_pkg::BUS_RST;
      mux_bus_oe  <= 1'b0;
      wr_data     <= mbp_pkg::BUS_RST;
      wr_strobe   <= 1'b0;
    end else begin
      mux_bus_out <= rd_data; // R15
      mux_bus_oe  <= next_bus_oe;
      if ((st == mbp_pkg::ST_CMD) && cyc_write && !cmd_s) begin
        wr_data <= bus_s; // R15
      end
      wr_strobe <= (st == mbp_pkg::ST_CMD) && cyc_write && ph.cmd_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select / backoff line

  logic pend;
  logic ack_now;
  logic next_sel;

  assign ack_now = pend && (st == mbp_pkg::ST_IDLE) && !ale_s && !cmd_s; // R7

  // a new request in the ack cycle wins, so no change is ever lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend        <= 1'b0;
      backoff_ack <= 1'b0;
    end else begin
      backoff_ack <= ack_now;
      if (req_change) begin
        pend <= 1'b1;
      end else if (ack_now) begin
        pend <= 1'b0; // R7 R5
      end
    end
  end

  // wake runs regardless of the bus clock, which may be stopped
  assign next_sel = ((st == mbp_pkg::ST_CLAIM) && ale_s) ||        // R6 R17
                    ((st == mbp_pkg::ST_IDLE) && !ale_s && pend) || // R7 R4
                    ((st == mbp_pkg::ST_IDLE) && stop_clock_mode && wake_req); // R8

  // open drain style: low while driven, released otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      select_backoff_n_oe  <= 1'b0; // R25
      select_backoff_n_out <= 1'b1;
    end else begin
      select_backoff_n_oe  <= next_sel; // R6
      select_backoff_n_out <= !next_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ready line

  logic in_cmd;
  logic ext;
  assign in_cmd = (st == mbp_pkg::ST_CMD) && !ph.cmd_rise;

  // pulled low only after command is active; released when command ends
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iochrdy_oe  <= 1'b0; // R25
      iochrdy_out <= 1'b1;
      ext         <= 1'b0;
    end else if (!in_cmd) begin
      iochrdy_oe  <= 1'b0; // R9
      iochrdy_out <= 1'b1;
      ext         <= 1'b0;
    end else if (busy) begin
      iochrdy_oe  <= 1'b1; // R9 R20
      iochrdy_out <= 1'b0;
      ext         <= 1'b1;
    end else if (ext && !iochrdy_out && (!cyc_fast || ph.bclk_fall)) begin
      iochrdy_out <= 1'b1; // R21 R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_SEL_CLAIM: assert property (@(posedge clk) disable iff (!reset_n) // R6
    ((st == mbp_pkg::ST_CLAIM) && ale_s) |=> select_backoff_n_oe && !select_backoff_n_out)
    else $error("claim not driven while address latch high");
  AST_SEL_RELEASE: assert property (@(posedge clk) disable iff (!reset_n) // R6
    ((st != mbp_pkg::ST_CLAIM) && (st != mbp_pkg::ST_IDLE)) |=> !select_backoff_n_oe)
    else $error("select driven outside claim and idle");
  AST_BACKOFF: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (pend && (st == mbp_pkg::ST_IDLE) && !ale_s) |=> select_backoff_n_oe)
    else $error("pending request not driven on select");
  AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (!reset_n) // R7
    (ack_now && !req_change) |=> !pend && backoff_ack)
    else $error("acknowledged request not cleared");
  AST_WAKE: assert property (@(posedge clk) disable iff (!reset_n) // R8
    ((st == mbp_pkg::ST_IDLE) && stop_clock_mode && wake_req) |=> select_backoff_n_oe)
    else $error("wake request not driven");
  AST_CLAIM_HIT: assert property (@(posedge clk) disable iff (!reset_n) // R17
    ((st == mbp_pkg::ST_IDLE) && ph.ale_rise && hit) |=> (st == mbp_pkg::ST_CLAIM) ##1
      select_backoff_n_oe)
    else $error("own cycle not claimed");
  AST_EXTEND: assert property (@(posedge clk) disable iff (!reset_n) // R9 R20
    (in_cmd && busy) |=> iochrdy_oe && !iochrdy_out)
    else $error("busy did not pull ready low");
  AST_NO_EXTEND_EARLY: assert property (@(posedge clk) disable iff (!reset_n) // R20
    (st != mbp_pkg::ST_CMD) |=> !iochrdy_oe)
    else $error("ready driven outside command");
  AST_FAST_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // R21
    (in_cmd && cyc_fast && !busy && iochrdy_oe && !iochrdy_out && !ph.bclk_fall)
      |=> !iochrdy_out)
    else $error("fast ready released off a falling bus clock edge");
  AST_STD_RELEASE: assert property (@(posedge clk) disable iff (!reset_n) // R23
    (in_cmd && !cyc_fast && !busy && iochrdy_oe && !iochrdy_out) |=> iochrdy_out)
    else $error("standard ready not released at once");

  // hand-over, data phase, foreign cycle and backoff checks
  AST_START_DATA: assert property (@(posedge clk) disable iff (!reset_n) // R17
    cyc_start |-> (st == mbp_pkg::ST_DATA))
    else $error("start pulse outside data phase");
  AST_MISS_SKIP: assert property (@(posedge clk) disable iff (!reset_n) // R17 R24
    ((st == mbp_pkg::ST_IDLE) && ph.ale_rise && !hit) |=> (st == mbp_pkg::ST_SKIP))
    else $error("foreign cycle not parked");
  AST_SKIP_QUIET: assert property (@(posedge clk) disable iff (!reset_n) // R11 R24
    (st == mbp_pkg::ST_SKIP) |=> !cyc_start && !mux_bus_oe && !iochrdy_oe)
    else $error("foreign cycle answered");
  AST_READ_DRIVE: assert property (@(posedge clk) disable iff (!reset_n) // R19
    ((st == mbp_pkg::ST_CMD) && !cyc_write && !ph.cmd_rise) |=> mux_bus_oe)
    else $error("read data not driven during command");
  AST_WRITE_FLOAT: assert property (@(posedge clk) disable iff (!reset_n) // R19
    mux_bus_oe |-> !cyc_write)
    else $error("bus driven during a write");
  AST_BUS_IDLE: assert property (@(posedge clk) disable iff (!reset_n) // R19
    (st == mbp_pkg::ST_IDLE) |=> !mux_bus_oe)
    else $error("bus driven while idle");
  AST_WR_STROBE: assert property (@(posedge clk) disable iff (!reset_n) // R15
    ((st == mbp_pkg::ST_CMD) && cyc_write && ph.cmd_rise)
      |=> wr_strobe && (st == mbp_pkg::ST_IDLE))
    else $error("write strobe missing at command end");
  AST_WR_STABLE: assert property (@(posedge clk) disable iff (!reset_n) // R15
    wr_strobe |-> $stable(wr_data))
    else $error("write data moved under its strobe");
  AST_ACK_IDLE: assert property (@(posedge clk) disable iff (!reset_n) // R7 R5
    backoff_ack |-> ($past(st) == mbp_pkg::ST_IDLE))
    else $error("backoff acknowledged outside idle");
  AST_READY_END: assert property (@(posedge clk) disable iff (!reset_n) // R9
    ((st == mbp_pkg::ST_CMD) && ph.cmd_rise) |=> !iochrdy_oe)
    else $error("ready still driven after command");
endmodule

// ===== rtl/mbp_pkg.sv
package mbp_pkg;
  // multiplexed bus shape
  localparam int BUS_W   = 16;
  localparam int ADDR_W  = 24;
  localparam int AHI_W   = 14;
  localparam int ALO_W   = 10;
  // phase one fields
  localparam int P1_MIO_BIT = 0;
  localparam int P1_IOD_BIT = 1;
  localparam int P1_AHI_LSB = 2;
  // phase two fields
  localparam int P2_WR_BIT   = 0;
  localparam int P2_BHE_BIT  = 1;
  localparam int P2_FAST_BIT = 2;
  localparam int P2_ALO_LSB  = 6;
  // synchroniser layout: {bus_clock, ale, cmd_n, mux_bus}
  localparam int SYNC_W       = 19;
  localparam int SYNC_CMD_BIT = 16;
  localparam int SYNC_ALE_BIT = 17;
  localparam int SYNC_BCK_BIT = 18;
  // reset values
  localparam logic [15:0] BUS_RST  = 16'h0000;
  localparam logic [23:0] ADDR_RST = 24'h00_0000;
  localparam logic [18:0] SYNC_RST = 19'h1_0000;
  // cycle tracking states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CLAIM = 3'b001,
    ST_DATA  = 3'b010,
    ST_CMD   = 3'b011,
    ST_SKIP  = 3'b100
  } mbp_state_t;
endpackage

// ===== rtl/mbp_phase_if.sv
interface mbp_phase_if;
  logic        p1_en;
  logic [15:0] p1;
  logic [15:0] p2;
  logic        bclk_rise;
  logic        bclk_fall;
  logic        ale_rise;
  logic        cmd_rise;
  logic        cmd_fall;
  modport capture (input p1_en, output p1, p2, bclk_rise, bclk_fall, ale_rise,
                   cmd_rise, cmd_fall);
  modport user (output p1_en, input p1, p2, bclk_rise, bclk_fall, ale_rise,
                cmd_rise, cmd_fall);
endinterface

// ===== rtl/mbp_sync.sv
module mbp_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // two flops per bit; only the second stage is ever read
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        meta[i] <= RST_VAL[i];
        q[i]    <= RST_VAL[i];
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end
endmodule

// ===== rtl/mbp_phase.sv
module mbp_phase (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // synchronised bus pins
  input  wire logic [15:0] bus_s,
  input  wire logic        bclk_s,
  input  wire logic        ale_s,
  input  wire logic        cmd_s,
  // captured phases and edges
  mbp_phase_if.capture     ph
);
  logic bclk_d;
  logic ale_d;
  logic cmd_d;

  // previous samples for edge finding
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_d <= 1'b0;
      ale_d  <= 1'b0;
      cmd_d  <= 1'b1;
    end else begin
      bclk_d <= bclk_s;
      ale_d  <= ale_s;
      cmd_d  <= cmd_s;
    end
  end

  assign ph.bclk_rise = bclk_s & ~bclk_d;
  assign ph.bclk_fall = ~bclk_s & bclk_d;
  assign ph.ale_rise  = ale_s & ~ale_d;
  assign ph.cmd_fall  = ~cmd_s & cmd_d;
  assign ph.cmd_rise  = cmd_s & ~cmd_d;

  // phase one on bus clock rise, phase two on address latch rise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph.p1 <= mbp_pkg::BUS_RST;
      ph.p2 <= mbp_pkg::BUS_RST;
    end else begin
      if (ph.bclk_rise && ph.p1_en) begin
        ph.p1 <= bus_s; // R2
      end
      if (ph.ale_rise) begin
        ph.p2 <= bus_s; // R3
      end
    end
  end

  AST_P1_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (ph.bclk_rise && ph.p1_en) |=> (ph.p1 == $past(bus_s)))
    else $error("phase one not taken on bus clock rise");
  AST_P2_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n) // R3
    ph.ale_rise |=> (ph.p2 == $past(bus_s)) ##1 $stable(ph.p2))
    else $error("phase two not taken on address latch rise");
endmodule

// ===== testbench/mbp_host.sv
module mbp_host (
  // clock
  input  wire logic        clk,
  // pins the host drives
  output logic             bus_clock,
  output logic             ale,
  output logic             cmd_n,
  output logic [15:0]      mux_bus,
  // device side of the shared lines
  input  wire logic [15:0] dev_d,
  input  wire logic        dev_oe,
  input  wire logic        sel_n,
  input  wire logic        rdy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        drv = 1'b0;
  logic [15:0] hd  = 16'h0000;
  logic [15:0] flt = 16'h0000;
  initial begin
    bus_clock = 1'b0;
    ale = 1'b0;
    cmd_n = 1'b1;
  end
  // a floating bus flips every cycle, so a stale value never passes for data
  always @(posedge clk) flt <= ~mux_bus;
  assign mux_bus = (drv && dev_oe) ? 16'hxxxx : (drv ? hd : (dev_oe ? dev_d : flt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // half a bus clock period is four system clocks
  task automatic edge_to(input logic lvl);
    step(4);
    bus_clock = lvl;
  endtask
  // one cycle; the bus clock stands still outside it
  task automatic mem_cycle(input logic [15:0] p1, input logic [15:0] p2,
                           input logic [15:0] wd, output logic claim, output logic [15:0] rd);
    step(4);
    drv = 1'b1;
    hd = p1;
    edge_to(1'b1);
    edge_to(1'b0);
    hd = p2;
    ale = 1'b1;
    claim = 1'b0;
    for (int i = 0; i < 4 && !claim; i++) begin
      edge_to(1'b1);
      claim = (sel_n === 1'b0);
      if (claim || i == 3) ale = 1'b0;
      edge_to(1'b0);
    end
    drv = p2[0];
    hd = wd;
    edge_to(1'b1);
    cmd_n = 1'b0;
    for (int i = 0; i < 40; i++) begin
      edge_to(1'b0);
      edge_to(1'b1);
      if (rdy === 1'b1) break;
    end
    // standard timing ends one bus clock after ready is seen high
    if (!p2[2]) begin
      edge_to(1'b0);
      edge_to(1'b1);
    end
    rd = mux_bus;
    cmd_n = 1'b1;
    edge_to(1'b0);
    drv = 1'b0;
  endtask
  // acknowledge a backoff request with a command pulse while ale is low
  task automatic ack();
    cmd_n = 1'b0;
    step(4);
    cmd_n = 1'b1;
    step(4);
  endtask
endmodule

// ===== testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk             = 1'b0;
  logic        reset_n;
  logic [13:0] win_base;
  logic [13:0] win_mask;
  logic        req_change;
  logic        stop_clock_mode;
  logic        wake_req;
  logic        busy;
  logic [15:0] rd_data;
  logic        bus_clock, ale, cmd_n, dev_oe, sel_out, sel_oe, rdy_out, rdy_oe;
  logic        backoff_ack, cyc_start, cyc_write, cyc_bhe_n, cyc_fast, wr_strobe;
  logic [15:0] mux_bus, dev_d, wr_data, c_wd;
  logic [23:0] cyc_addr, c_addr;
  logic [2:0]  c_ctl;
  // select and ready carry pull-ups, so released lines read high
  wire         sel_w = sel_oe ? sel_out : 1'b1;
  wire         rdy_w = rdy_oe ? rdy_out : 1'b1;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          n_start = 0, n_ack = 0, n_rlow = 0, busy_len = 0, cmd_cnt = 0, n_clk = 0;
  time         t_bfall = 0, t_bsy = 0, gap_f = 0, gap_b = 0;
  ////////////////////////////////////////////////////////////////////////////////
  mbp_port uut (
    .clk(clk), .reset_n(reset_n), .bus_clock(bus_clock), .ale(ale), .cmd_n(cmd_n),
    .mux_bus_in(mux_bus), .mux_bus_out(dev_d), .mux_bus_oe(dev_oe),
    .select_backoff_n_out(sel_out), .select_backoff_n_oe(sel_oe),
    .iochrdy_out(rdy_out), .iochrdy_oe(rdy_oe), .win_base(win_base), .win_mask(win_mask),
    .req_change(req_change), .stop_clock_mode(stop_clock_mode), .wake_req(wake_req),
    .backoff_ack(backoff_ack), .cyc_start(cyc_start), .cyc_addr(cyc_addr),
    .cyc_write(cyc_write), .cyc_bhe_n(cyc_bhe_n), .cyc_fast(cyc_fast), .busy(busy),
    .rd_data(rd_data), .wr_data(wr_data), .wr_strobe(wr_strobe));
  mbp_host host (
    .clk(clk), .bus_clock(bus_clock), .ale(ale), .cmd_n(cmd_n), .mux_bus(mux_bus),
    .dev_d(dev_d), .dev_oe(dev_oe), .sel_n(sel_w), .rdy(rdy_w));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  // busy follows the command for busy_len clocks, then drops
  always @(posedge clk) begin
    cmd_cnt = (cmd_n === 1'b0) ? cmd_cnt + 1 : 0;
    #2;
    busy = (cmd_cnt > 0) && (cmd_cnt <= busy_len);
  end
  // capture the hand-over, count wait clocks, cut a hang short
  always @(posedge clk) begin
    n_clk++;
    if (rdy_w === 1'b0) n_rlow++;
    if (cyc_start === 1'b1) begin
      n_start++;
      c_addr = cyc_addr;
      c_ctl = {cyc_fast, cyc_bhe_n, cyc_write};
    end
    if (wr_strobe === 1'b1) c_wd = wr_data;
    if (backoff_ack === 1'b1) n_ack++;
    if (n_clk == 8000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // time the ready release against its two possible causes
  always @(negedge bus_clock) t_bfall = $time;
  always @(negedge busy) t_bsy = $time;
  always @(posedge rdy_w) begin
    gap_f = $time - t_bfall;
    gap_b = $time - t_bsy;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one claimed memory cycle with its hand-over checked
  task automatic do_mem(input logic [13:0] hi, input logic [9:0] lo, input logic [2:0] ctl,
                        input logic [2:0] same, input int blen);
    logic        claim;
    logic [15:0] rd;
    int          s0;
    s0 = n_start;
    n_rlow = 0;
    busy_len = blen;
    rd_data = {lo[5:0], hi[9:0]};
    host.mem_cycle({hi, 2'b01}, {lo, same, ctl}, {lo, hi[5:0]}, claim, rd);
    host.step(8);
    chk("claim", 1, claim);
    chk("start pulse", s0 + 1, n_start);
    chk("cycle fields", {hi, lo, ctl}, {c_addr, c_ctl});
    chk("lines released", 1, {sel_oe, rdy_oe, dev_oe, sel_w} === 4'b0001);
    if (ctl[0]) chk("write data", {lo, hi[5:0]}, c_wd);
    else chk("read data", rd_data, rd);
  endtask
  task automatic t_fast_write();
    do_mem(14'h2d5a, 10'h1c6, 3'b101, 3'b101, 0);
    chk("no wait", 0, n_rlow);
  endtask
  // out of window, io, and memory with io/dma set: none is claimed
  task automatic t_refuse();
    logic        claim;
    logic [15:0] rd;
    logic [15:0] p1 [3];
    int          s0;
    p1 = '{{14'h1d5a, 2'b01}, {14'h2d5a, 2'b10}, {14'h2d5a, 2'b11}};
    s0 = n_start;
    foreach (p1[i]) begin
      host.mem_cycle(p1[i], 16'h5544, 16'h0000, claim, rd);
      chk("refused claim", 0, claim);
    end
    chk("refused starts", s0, n_start);
  endtask
  // fast read stretched by busy; release waits for a bus clock fall
  task automatic t_fast_read();
    do_mem(14'h2d5f, 10'h3ff, 3'b110, 3'b010, 12);
    chk("wait seen", 1, n_rlow > 0);
    chk("release on fall", 1, gap_f > 40 && gap_f <= 150);
  endtask
  task automatic t_std_write();
    do_mem(14'h2d50, 10'h2a5, 3'b011, 3'b000, 10);
    chk("wait seen", 1, n_rlow > 0);
    chk("prompt release", 1, gap_b <= 75);
  endtask
  task automatic t_backoff();
    int s0;
    s0 = n_ack;
    req_change = 1'b1;
    host.step(1);
    req_change = 1'b0;
    host.step(4);
    chk("backoff request", 0, sel_w);
    host.ack();
    chk("backoff ack", s0 + 1, n_ack);
    chk("request withdrawn", 1, sel_w);
  endtask
  task automatic t_wake();
    stop_clock_mode = 1'b1;
    wake_req = 1'b1;
    host.step(3);
    chk("wake request", 0, sel_w);
    wake_req = 1'b0;
    stop_clock_mode = 1'b0;
    host.step(3);
    chk("wake withdrawn", 1, sel_w);
    wake_req = 1'b1;
    host.step(3);
    chk("wake needs stop mode", 1, sel_w);
    wake_req = 1'b0;
  endtask
  // a reset in mid-request floats the line and forgets the request
  task automatic t_reset_mid();
    req_change = 1'b1;
    host.step(1);
    req_change = 1'b0;
    host.step(4);
    chk("request before reset", 0, sel_w);
    reset_n = 1'b0;
    host.step(1);
    chk("reset floats", 3'b000, {sel_oe, rdy_oe, dev_oe});
    reset_n = 1'b1;
    host.step(6);
    chk("request dropped", 1, sel_w);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n         = 1'b0;
    win_base        = 14'h2d5a;
    win_mask        = 14'h3ff0;
    req_change      = 1'b0;
    stop_clock_mode = 1'b0;
    wake_req        = 1'b0;
    rd_data         = 16'hc35a;
    repeat (8) @(posedge clk);
    #2;
    chk("reset floats", 3'b000, {sel_oe, rdy_oe, dev_oe});
    reset_n = 1'b1;
    host.step(4);
    t_fast_write();
    t_refuse();
    t_fast_read();
    t_std_write();
    t_backoff();
    t_wake();
    t_reset_mid();
    wrap_up();
  end
endmodule
